// ===== hdl/pcs_pkg.sv
package pcs_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int PC_W    = 13;   // 8K-word space
   localparam int INSTR_W = 16;   // Word width
   localparam int DEPTH   = 8;    // Return levels
   localparam int SP_W    = 3;    // Level index

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_PC_LOW = 8'h00;  // pc_low_byte
   localparam logic [7:0] OFS_STATUS = 8'h04;  // Sequencer state, read only

   // Status fields
   localparam int ST_PC_HIGH_LSB = 0;   // pc_high_bits
   localparam int ST_PHASE_LSB   = 8;   // One-hot phase
   localparam int ST_VALID_BIT   = 16;  // Executing a real word
   localparam int ST_HELD_BIT    = 17;  // Interrupt waits for a level
   localparam int ST_PEND_BIT    = 18;  // Low-byte jump not yet applied

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [PC_W-1:0] PC_RESET  = 13'h0000;
   localparam logic [SP_W-1:0] SP_RESET  = 3'h0;
   localparam logic [31:0]     RD_UNMAPD = 32'h0000_0000;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HTRANS_SEQ    = 2'b11;
   localparam logic       HRESP_OKAY    = 1'b0;

   // ****************************************
   // Instruction cycle phases
   // ****************************************
   typedef enum logic [3:0] {
      PCS_PH_FETCH = 4'b0001,   // fetch_phase
      PCS_PH_DEC   = 4'b0010,   // decode_execute_phases, first
      PCS_PH_EXE   = 4'b0100,
      PCS_PH_WB    = 4'b1000    // Last phase, steering decided here
   } pcs_phase_t;
endpackage

// ===== hdl/pcs_phase_gen.sv
`timescale 1ns/1ps
module pcs_phase_gen (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // Phase state
   output pcs_pkg::pcs_phase_t    phase,
   output logic                   last_phase
);
   // ****************************************
   // Four-phase rotator
   // ****************************************
   pcs_pkg::pcs_phase_t phase_q;   // Current phase
   pcs_pkg::pcs_phase_t phase_d;   // Next phase

   // Each phase is one system clock; phases never overlap
   always_comb begin
      unique case (phase_q)
         pcs_pkg::PCS_PH_FETCH : phase_d = pcs_pkg::PCS_PH_DEC;
         pcs_pkg::PCS_PH_DEC   : phase_d = pcs_pkg::PCS_PH_EXE;
         pcs_pkg::PCS_PH_EXE   : phase_d = pcs_pkg::PCS_PH_WB;
         pcs_pkg::PCS_PH_WB    : phase_d = pcs_pkg::PCS_PH_FETCH;
         // Recover from an illegal code
         default               : phase_d = pcs_pkg::PCS_PH_FETCH;
      endcase
   end

   // Rotation register, starts in the fetch phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= pcs_pkg::PCS_PH_FETCH;
      end else begin
         phase_q <= phase_d;
      end
   end

   assign phase      = phase_q;
   assign last_phase = (phase_q == pcs_pkg::PCS_PH_WB);
endmodule

// ===== hdl/pcs_ret_stack.sv
`timescale 1ns/1ps
module pcs_ret_stack (
   // Clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // Requests, one-cycle pulses
   input  wire logic                      push,
   input  wire logic                      pop,
   input  wire logic [pcs_pkg::PC_W-1:0]  push_val,
   // State
   output logic      [pcs_pkg::PC_W-1:0]  top_val,
   output logic                           full
);
   // ****************************************
   // Storage and pointer
   // ****************************************
   logic [pcs_pkg::PC_W-1:0] mem_q [pcs_pkg::DEPTH];  // Saved counters
   logic [pcs_pkg::SP_W-1:0] sp_q;                    // Next free level
   logic [pcs_pkg::SP_W:0]   cnt_q;                   // Levels in use

   // Array holds no control state, so it needs no reset
   always_ff @(posedge hclk) begin
      if (push) begin
         mem_q[sp_q] <= push_val;
      end
   end

   // Pointer wraps, so a push into a full stack overwrites the oldest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_q  <= pcs_pkg::SP_RESET;
         cnt_q <= '0;
      end else if (push) begin
         sp_q <= sp_q + 3'h1;
         if (!full) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end else if (pop) begin
         sp_q <= sp_q - 3'h1;
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end

   assign top_val = mem_q[sp_q - 3'h1];
   assign full    = (cnt_q == 4'(pcs_pkg::DEPTH));
endmodule

// ===== hdl/pcs_sequencer.sv
`timescale 1ns/1ps
module pcs_sequencer (
   // Clock and reset
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   // AHB-Lite slave
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   // Program memory
   output logic      [pcs_pkg::PC_W-1:0]     pmem_addr,
   output logic                              pmem_rd,
   input  wire logic [pcs_pkg::INSTR_W-1:0]  pmem_data,
   // Execute unit
   output logic      [pcs_pkg::INSTR_W-1:0]  instr_word,
   output logic                              instr_valid,
   output logic                              fetch_phase,
   output logic                              decode_execute_phases,
   input  wire logic                         op_branch,
   input  wire logic                         op_call,
   input  wire logic                         subroutine_exit_op,
   input  wire logic                         interrupt_exit_op,
   input  wire logic                         op_skip,
   input  wire logic [pcs_pkg::PC_W-1:0]     branch_target,
   // Interrupt logic
   input  wire logic                         irq_pending,
   input  wire logic [pcs_pkg::PC_W-1:0]     irq_vector,
   output logic                              irq_ack
);
   // ****************************************
   // Phase generation
   // ****************************************
   pcs_pkg::pcs_phase_t phase;      // Current phase
   logic                last_ph;    // Final phase of the cycle

   pcs_phase_gen u_phase (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .phase      (phase),
      .last_phase (last_ph)
   );

   assign fetch_phase           = (phase == pcs_pkg::PCS_PH_FETCH);
   assign decode_execute_phases = !fetch_phase;
   assign pmem_rd               = fetch_phase;

   // ****************************************
   // Declarations
   // ****************************************
   logic [pcs_pkg::PC_W-1:0]    pc_q;          // Fetch address
   logic [pcs_pkg::PC_W-1:0]    pc_d;          // Next fetch address
   logic [pcs_pkg::INSTR_W-1:0] instr_q;       // Word in execution
   logic                        valid_q;       // Not a dummy cycle
   logic                        flush;         // Drop prefetched word
   logic                        act;           // Real word, last phase
   logic                        do_call;       // Push for a call
   logic                        do_ret;        // Pop for a return
   logic                        do_jump;       // Direct load
   logic                        do_pcl;        // Apply low-byte write
   logic                        do_irq;        // Acknowledge now
   logic                        irq_held;      // Waiting for a level
   logic                        ack_q;         // Acknowledge pulse
   logic                        stk_full;      // All levels in use
   logic [pcs_pkg::PC_W-1:0]    stk_top;       // Newest entry
   logic [7:0]                  pcl_data_q;    // Written low byte
   logic                        pcl_pend_q;    // Write waiting
   logic                        pcl_wr;        // Write accepted now

   // ****************************************
   // Control decision, last phase only
   // ****************************************
   // Commands on a dummy cycle belong to a flushed word
   assign act     = last_ph && valid_q;
   assign do_call = act && op_call;
   assign do_ret  = act && (subroutine_exit_op || interrupt_exit_op);
   assign do_jump = act && op_branch && !op_call;
   // A low-byte write yields to an instruction's own transfer
   assign do_pcl  = last_ph && pcl_pend_q && !(do_call || do_ret || do_jump);
   // Acknowledge only on a quiet boundary with a free level
   assign irq_held = irq_pending && stk_full;
   assign do_irq   = last_ph && irq_pending && !stk_full
                     && !(do_call || do_ret || do_jump || do_pcl);

   // Next fetch address and flush
   always_comb begin
      pc_d  = pc_q + 13'h0001;
      flush = 1'b0;
      if (do_call || do_jump) begin
         pc_d  = branch_target;
         flush = 1'b1;
      end else if (do_ret) begin
         pc_d  = stk_top;
         flush = 1'b1;
      end else if (do_pcl) begin
         pc_d  = {pc_q[pcs_pkg::PC_W-1:8], pcl_data_q};
         flush = 1'b1;
      end else if (do_irq) begin
         pc_d  = irq_vector;
         flush = 1'b1;
      end else if (act && op_skip) begin
         flush = 1'b1;
      end
   end

   // ****************************************
   // Program counter
   // ****************************************
   // Changes only on the edge that opens the fetch phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_q <= pcs_pkg::PC_RESET;
      end else if (last_ph) begin
         pc_q <= pc_d;
      end
   end

   assign pmem_addr = pc_q;

   // ****************************************
   // Execute register
   // ****************************************
   // Word fetched this cycle executes in the next; first cycle is empty
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_q <= '0;
         valid_q <= 1'b0;
      end else if (last_ph) begin
         instr_q <= pmem_data;
         valid_q <= !flush;
      end
   end

   assign instr_word  = instr_q;
   assign instr_valid = valid_q;

   // ****************************************
   // Return stack
   // ****************************************
   // Pushed value is the fetch address, so the flushed word reruns
   pcs_ret_stack u_stack (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .push     (do_call || do_irq),
      .pop      (do_ret),
      .push_val (pc_q),
      .top_val  (stk_top),
      .full     (stk_full)
   );

   // Acknowledge pulse to the interrupt logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= do_irq;
      end
   end

   assign irq_ack = ack_q;

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   logic       ap_wr_q;    // Data phase is a write
   logic       ap_rd_q;    // Data phase is a read
   logic [7:0] ap_ofs_q;   // Latched offset
   logic       ap_take;    // Address phase accepted

   // Zero wait states; every answer is OKAY
   assign hreadyout = 1'b1;
   assign hresp     = pcs_pkg::HRESP_OKAY;
   assign ap_take   = hsel && hready && (htrans == pcs_pkg::HTRANS_NONSEQ
                                         || htrans == pcs_pkg::HTRANS_SEQ);

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q  <= 1'b0;
         ap_rd_q  <= 1'b0;
         ap_ofs_q <= '0;
      end else if (hready) begin
         ap_wr_q  <= ap_take && hwrite;
         ap_rd_q  <= ap_take && !hwrite;
         ap_ofs_q <= haddr[7:0];
      end
   end

   // Only the low byte accepts writes; stack stays unmapped
   assign pcl_wr = ap_wr_q && (ap_ofs_q == pcs_pkg::OFS_PC_LOW);

   // Pending low-byte jump: a new write wins over the apply
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pcl_pend_q <= 1'b0;
         pcl_data_q <= '0;
      end else if (pcl_wr) begin
         pcl_pend_q <= 1'b1;
         pcl_data_q <= hwdata[7:0];
      end else if (do_pcl) begin
         pcl_pend_q <= 1'b0;
      end
   end

   // Read data comes from flops, set up during the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= pcs_pkg::RD_UNMAPD;
      end else if (ap_take && !hwrite) begin
         unique case (haddr[7:0])
            pcs_pkg::OFS_PC_LOW : hrdata <= {24'h00_0000, pc_d[7:0] & 8'hFF};
            pcs_pkg::OFS_STATUS : begin
               hrdata <= pcs_pkg::RD_UNMAPD;
               hrdata[pcs_pkg::ST_PC_HIGH_LSB +: 5] <= pc_q[pcs_pkg::PC_W-1:8];
               hrdata[pcs_pkg::ST_PHASE_LSB +: 4]   <= phase;
               hrdata[pcs_pkg::ST_VALID_BIT]        <= valid_q;
               hrdata[pcs_pkg::ST_HELD_BIT]         <= irq_held;
               hrdata[pcs_pkg::ST_PEND_BIT]         <= pcl_pend_q;
            end
            default : hrdata <= pcs_pkg::RD_UNMAPD;
         endcase
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic boot_q;   // High until the first cycle boundary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         boot_q <= 1'b1;
      end else if (last_ph) begin
         boot_q <= 1'b0;
      end
   end

   a_phase_rotation: assert property (
      fetch_phase |=> (phase == pcs_pkg::PCS_PH_DEC) ##1 (phase == pcs_pkg::PCS_PH_EXE)
                      ##1 last_ph ##1 fetch_phase)
      else $error("phase order broken");

   a_addr_at_fetch: assert property (
      $changed(pmem_addr) |-> fetch_phase && $past(last_ph))
      else $error("fetch address moved outside phase one");

   a_plain_increment: assert property (
      last_ph && !flush && !do_call && !do_ret && !do_jump && !do_pcl && !do_irq
      |=> pmem_addr == $past(pmem_addr) + 13'h0001 ##0 instr_valid)
      else $error("sequential step wrong");

   // A low-byte jump or acknowledge may also flush the dummy cycle's fetch
   a_branch_two_cyc: assert property (
      act && op_branch |=> pmem_addr == $past(branch_target) ##0 !instr_valid
                           ##4 (instr_valid || $past(flush)))
      else $error("branch did not take two cycles");

   a_skip_dummy: assert property (
      act && op_skip && !op_branch && !op_call && !subroutine_exit_op && !interrupt_exit_op
      && !pcl_pend_q && !irq_pending |=> !instr_valid ##0 pmem_addr == $past(pmem_addr) + 13'h0001)
      else $error("skip did not flush");

   a_pcl_page_jump: assert property (
      do_pcl |=> pmem_addr == {$past(pc_q[12:8]), $past(pcl_data_q)} ##0 !instr_valid)
      else $error("low-byte jump left page");

   a_irq_held_full: assert property (
      stk_full |=> !irq_ack)
      else $error("acknowledge with full stack");

   a_ret_restore: assert property (
      do_ret |=> pmem_addr == $past(stk_top))
      else $error("return address wrong");

   a_boot_zero: assert property (
      boot_q |-> pmem_addr == pcs_pkg::PC_RESET && !instr_valid)
      else $error("reset did not start at zero");

   // Phase register must stay one-hot even without the recovery branch
   a_phase_onehot: assert property (
      $onehot(phase))
      else $error("phase code not one-hot");

   // Acknowledge lands together with the vector load and a flushed word
   a_ack_vector: assert property (
      irq_ack |-> pmem_addr == $past(irq_vector) && !instr_valid)
      else $error("acknowledge without vector load");

   // A longer pulse would let the interrupt logic clear a second request
   a_ack_single: assert property (
      irq_ack |=> !irq_ack)
      else $error("acknowledge longer than one clock");

   // Both push sources save the fetch address that was about to run
   a_push_saves: assert property (
      do_call || do_irq |=> stk_top == $past(pc_q))
      else $error("pushed value is not the counter");

   // Overflowing call still branches; the level count stays at full
   a_overflow_call: assert property (
      do_call && stk_full |=> stk_full && pmem_addr == $past(branch_target))
      else $error("call on full stack misbehaved");

   // A return on a full stack must release the held interrupt
   a_ret_frees: assert property (
      do_ret && stk_full |=> !stk_full)
      else $error("return did not free a level");

   // Pointer and level count start empty after any reset
   a_reset_sp: assert property (
      boot_q |-> !stk_full)
      else $error("stack not empty after reset");

   c_call_taken:  cover property (do_call ##[4:40] do_ret);
   c_irq_waited:  cover property (irq_held ##[1:40] irq_ack);
   c_pcl_jump:    cover property (pcl_wr ##[1:8] do_pcl);
   c_skip_taken:  cover property (act && op_skip ##1 !instr_valid);
   c_overflow:    cover property (do_call && stk_full);
endmodule

// ===== tb/pcs_far_model.sv
`timescale 1ns/1ps
// ****************************************
// Program memory and interrupt source
// ****************************************
module pcs_far_model #(
   parameter logic [12:0] VEC = 13'h0004   // Vector address, any value serves
) (
   // Clock and reset
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   // Program memory side
   input  wire logic [pcs_pkg::PC_W-1:0]     pmem_addr,
   input  wire logic                         pmem_rd,
   output logic      [pcs_pkg::INSTR_W-1:0]  pmem_data,
   // Interrupt side
   input  wire logic                         irq_req,
   input  wire logic                         irq_ack,
   output logic                              irq_pending,
   output logic      [pcs_pkg::PC_W-1:0]     irq_vector
);
   // Every word carries its own address, so a wrong fetch shows at once
   // Read during the fetch phase; the word holds until the next fetch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pmem_data <= '0;
      end else if (pmem_rd) begin
         pmem_data <= {3'b101, pmem_addr};
      end
   end
   assign irq_vector = VEC;

   // Request flag stays up until acknowledged, as a held request must
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_pending <= 1'b0;
      end else if (irq_ack) begin
         irq_pending <= 1'b0;
      end else if (irq_req) begin
         irq_pending <= 1'b1;
      end
   end
endmodule

// ===== tb/program_counter_stack_sequencer_bench.sv
`timescale 1ns/1ps
module program_counter_stack_sequencer_bench;
   // ****************************************
   // Signals
   // ****************************************
   localparam logic [12:0] VEC = 13'h0004;   // Arbitrary vector
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_req, irq_ack, irq_pending;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [12:0] pmem_addr, branch_target, irq_vector, last_pc, prev_a, ack_a, stk[$];
   logic [15:0] pmem_data, instr_word;
   logic        pmem_rd, instr_valid, fetch_phase, decode_execute_phases;
   logic        op_branch, op_call, subroutine_exit_op, interrupt_exit_op, op_skip;
   int          err_total, num_checks, ack_cnt;

   assign hready = hreadyout;   // One slave drives the bus ready

   pcs_sequencer i_pcs_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pmem_addr(pmem_addr),
      .pmem_rd(pmem_rd), .pmem_data(pmem_data), .instr_word(instr_word), .instr_valid(instr_valid),
      .fetch_phase(fetch_phase), .decode_execute_phases(decode_execute_phases),
      .op_branch(op_branch), .op_call(op_call), .subroutine_exit_op(subroutine_exit_op),
      .interrupt_exit_op(interrupt_exit_op), .op_skip(op_skip), .branch_target(branch_target),
      .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_ack(irq_ack));

   pcs_far_model #(.VEC(VEC)) i_pcs_far_model (.hclk(hclk), .hresetn(hresetn), .pmem_addr(pmem_addr),
      .pmem_rd(pmem_rd), .pmem_data(pmem_data), .irq_req(irq_req), .irq_ack(irq_ack),
      .irq_pending(irq_pending), .irq_vector(irq_vector));

   // ****************************************
   // Clock, acknowledge monitor, watchdog
   // ****************************************
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // Sampled mid-cycle to stay clear of the edge updates
   always @(negedge hclk) begin
      if (irq_ack === 1'b1) begin
         ack_cnt++;
         ack_a = pmem_addr;
      end else if (ack_cnt == 0) begin
         prev_a = pmem_addr;
      end
   end

   // Whole run needs a few hundred clocks
   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      tally_and_finish();
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One single word transfer; waits on ready without a fixed count
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= pcs_pkg::HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   // Runs one real instruction; ops is {call, branch, return, interrupt return, skip}
   task automatic cyc(input logic [4:0] ops, input logic [12:0] tgt);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         #1;
         n++;
      end while (!(fetch_phase === 1'b1 && instr_valid === 1'b1) && n < 40);
      if (n >= 40) chk(n, 0);
      last_pc = pmem_addr;
      repeat (3) @(posedge hclk);
      {op_call, op_branch, subroutine_exit_op, interrupt_exit_op, op_skip} <= ops;
      branch_target <= tgt;
      @(posedge hclk);
      {op_call, op_branch, subroutine_exit_op, interrupt_exit_op, op_skip} <= 5'h00;
      #1;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk(pmem_addr, 0);
      chk(instr_valid, 0);
      @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge hclk);
         #1;
         chk({fetch_phase, decode_execute_phases, pmem_rd}, 3'b010);
      end
      @(posedge hclk);
      #1;
      chk({fetch_phase, pmem_rd, instr_valid}, 3'b111);
      chk(instr_word, 16'hA000);
      chk(pmem_addr, 13'h0001);
      cyc(5'h00, 13'h0000);
      chk(pmem_addr, last_pc + 13'h0001);
      chk(instr_word, {3'b101, last_pc});
      $display("test reset and sequencing done");
   endtask

   task automatic t_branch();
      cyc(5'b01000, 13'h1A40);
      chk(pmem_addr, 13'h1A40);
      chk(instr_valid, 0);
      repeat (4) @(posedge hclk);
      #1;
      chk({instr_valid, instr_word}, {1'b1, 16'hBA40});
      cyc(5'b00001, 13'h0000);
      chk(pmem_addr, last_pc + 13'h0001);
      chk(instr_valid, 0);
      $display("test branch and skip done");
   endtask

   task automatic t_low_byte();
      bus(1'b0, 32'h0000_0004, 32'h0000_0000);
      chk(rd[4:0], 5'h1A);
      chk({hreadyout, hresp}, 2'b10);
      bus(1'b1, 32'h0000_0000, 32'h0000_0037);
      for (int i = 0; i < 12 && pmem_addr !== 13'h1A37; i++) begin
         @(posedge hclk);
         #1;
      end
      chk(pmem_addr, 13'h1A37);
      chk(instr_valid, 0);
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      chk(rd[31:8], 24'h00_0000);
      chk(rd[7:0], 8'h38);
      bus(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000);
      chk(rd[4:0], 5'h1A);
      bus(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk(rd, pcs_pkg::RD_UNMAPD);
      $display("test low byte done");
   endtask

   task automatic t_stack();
      for (int i = 0; i < 9; i++) begin
         cyc(5'b10000, 13'h0100 + 13'(i * 16));
         stk.push_back(last_pc);
         if (stk.size() > 8) void'(stk.pop_front());
         chk(pmem_addr, 13'h0100 + 13'(i * 16));
      end
      for (int i = 0; i < 8; i++) begin
         cyc(i[0] ? 5'b00010 : 5'b00100, 13'h0000);
         chk(pmem_addr, stk.pop_back());
      end
      $display("test stack overflow done");
   endtask

   task automatic t_irq();
      for (int i = 0; i < 8; i++) cyc(5'b10000, 13'h0200 + 13'(i * 16));
      @(posedge hclk);
      irq_req <= 1'b1;
      @(posedge hclk);
      irq_req <= 1'b0;
      repeat (2) cyc(5'h00, 13'h0000);
      chk(ack_cnt, 0);
      chk(irq_pending, 1);
      cyc(5'b00100, 13'h0000);
      for (int i = 0; i < 4 && ack_cnt == 0; i++) cyc(5'h00, 13'h0000);
      chk(ack_cnt, 1);
      chk(ack_a, VEC);
      cyc(5'b00010, 13'h0000);
      chk(pmem_addr, prev_a);
      $display("test held interrupt done");
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      err_total = 0;
      num_checks = 0;
      ack_cnt = 0;
      hresetn = 1'b0;
      {hsel, hwrite, irq_req} = 3'b000;
      {haddr, hwdata} = 64'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      branch_target = 13'h0000;
      {op_call, op_branch, subroutine_exit_op, interrupt_exit_op, op_skip} = 5'h00;
      repeat (20) @(posedge hclk);
      t_reset();
      t_branch();
      t_low_byte();
      t_stack();
      t_irq();
      tally_and_finish();
   end
endmodule
